//--- pcbr_ring.sv
// profiling control block loader and event ring head logic
module pcbr_ring
  import pcbr_pkg::*;
#(
  parameter int          CW       = 26,
  parameter logic [31:0] REC_SIZE = 32'h00000020
)(
  input  wire logic          clk,          // core clock
  input  wire logic          rst_n,        // sync reset, active low
  input  wire logic          load_instr,   // load control block pulse
  input  wire logic          disable_req,  // stop profiling pulse
  input  wire logic [63:0]   pcb_addr,     // control block linear address
  input  wire logic [63:0]   seg_base,     // segment base for linear conversion
  input  wire logic [31:0]   feature_cfg,  // available feature bits
  input  wire logic          event_req,    // record store request pulse
  input  wire logic [63:0]   event_data,   // record word to store
  input  wire logic [CW-1:0] interval,     // event interval
  input  wire pcbr_mem_rsp_t mem_rsp,      // memory answer
  output pcbr_mem_req_t      mem_req,      // memory request
  output logic               enabled,      // session active
  output logic               busy,         // sequence in progress
  output logic               event_done,   // record handled pulse
  output logic               exception,    // access fault pulse
  output logic               thr_irq,      // threshold interrupt pulse
  output logic [31:0]        flags_en,     // features actually enabled
  output logic [7:0]         event_offset, // event area offset reported
  output logic [CW-1:0]      counter       // randomised event counter
);
  typedef enum {S_IDLE, S_RD_FLAGS, S_WR_FLAGS, S_RD_BASE, S_RD_HEAD, S_RD_THR,
                S_RD_TAIL, S_WR_REC, S_WR_HEAD, S_INC_DROP, S_RD_DROP, S_FAULT} pcbr_state_t;

  pcbr_state_t   st_reg, st_next;
  pcbr_mem_req_t req_reg, req_next;
  logic          en_reg, en_next, busy_reg, busy_next;
  logic          done_reg, done_next, exc_reg, exc_next, irq_reg, irq_next;
  logic [31:0]   flags_reg, flags_next, head_reg, head_next, tail_reg, tail_next;
  logic [31:0]   thr_reg, thr_next;
  logic [27:0]   size_reg, size_next;
  logic [3:0]    rnd_reg, rnd_next;
  logic [63:0]   base_reg, base_next, drop_reg, drop_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic          pend_reg, pend_next;
  logic [CW-1:0] rnd_word, reload_val;
  logic          rnd_step;

  pcbr_rand #(.W(CW)) u_rand (
    .clk   (clk),
    .rst_n (rst_n),
    .step  (rnd_step),
    .value (rnd_word)
  );

  pcbr_reload #(.W(CW)) u_reload (
    .interval  (interval),
    .rand_bits (rnd_reg),
    .rnd       (rnd_word),
    .reload    (reload_val)
  );

  // ==========================================================================
  // helpers
  function automatic logic [31:0] rdown(input logic [31:0] v);
    rdown = v - (v % REC_SIZE);
  endfunction

  logic [31:0] size32, head_adv, used;
  always_comb
  begin
    size32   = {4'h0, size_reg};
    head_adv = (head_reg + REC_SIZE >= size32) ? 32'h00000000 : head_reg + REC_SIZE;
    used     = (head_adv >= tail_reg) ? head_adv - tail_reg : head_adv + size32 - tail_reg;
  end

  function automatic pcbr_mem_req_t mk(input logic wr, input logic [63:0] a,
                                       input logic [63:0] d, input logic [1:0] sz);
    mk.valid = 1'b1;
    mk.write = wr;
    mk.addr  = a;
    mk.wdata = d;
    mk.size  = sz;
  endfunction

  // ==========================================================================
  // sequencer
  always_comb
  begin
    st_next    = st_reg;
    req_next   = req_reg;
    en_next    = en_reg;
    done_next  = 1'b0;
    exc_next   = 1'b0;
    irq_next   = 1'b0;
    flags_next = flags_reg;
    head_next  = head_reg;
    tail_next  = tail_reg;
    thr_next   = thr_reg;
    size_next  = size_reg;
    rnd_next   = rnd_reg;
    base_next  = base_reg;
    drop_next  = drop_reg;
    cnt_next   = cnt_reg;
    pend_next  = pend_reg | (event_req & en_reg);
    rnd_step   = 1'b0;
    busy_next  = (st_reg != S_IDLE);
    if (disable_req)
      en_next = 1'b0;
    if (req_reg.valid && mem_rsp.done && mem_rsp.fault)
    begin
      req_next = '0;
      st_next  = S_FAULT;
    end
    else
    begin
      case (st_reg)
        S_IDLE:
        begin
          if (load_instr)
          begin
            en_next  = 1'b0;
            req_next = mk(1'b0, pcb_addr + {56'h0, PCBR_OFF_FLAGS}, PCBR_ZERO64, 2'd1);
            st_next  = S_RD_FLAGS;
          end
          else if (pend_reg && en_reg)
          begin
            // tail is software owned, fetch it fresh for every record
            pend_next = 1'b0;
            req_next  = mk(1'b0, pcb_addr + {56'h0, PCBR_OFF_TAIL}, PCBR_ZERO64, 2'd0);
            st_next   = S_RD_TAIL;
          end
        end
        S_RD_FLAGS:
          if (mem_rsp.done)
          begin
            flags_next = mem_rsp.rdata[31:0] & feature_cfg;
            size_next  = mem_rsp.rdata[PCBR_SIZE_MSB:PCBR_SIZE_LSB] -
                         28'(mem_rsp.rdata[PCBR_SIZE_MSB:PCBR_SIZE_LSB] % REC_SIZE);
            rnd_next   = mem_rsp.rdata[PCBR_RAND_MSB:PCBR_RAND_LSB];
            req_next   = mk(1'b1, pcb_addr + {56'h0, PCBR_OFF_FLAGS},
                            {32'h0, mem_rsp.rdata[31:0] & feature_cfg}, 2'd0);
            st_next    = S_WR_FLAGS;
          end
        S_WR_FLAGS:
          if (mem_rsp.done)
          begin
            req_next = mk(1'b0, pcb_addr + {56'h0, PCBR_OFF_BASE}, PCBR_ZERO64, 2'd1);
            st_next  = S_RD_BASE;
          end
        S_RD_BASE:
          if (mem_rsp.done)
          begin
            base_next = mem_rsp.rdata + seg_base;
            req_next  = mk(1'b0, pcb_addr + {56'h0, PCBR_OFF_HEAD}, PCBR_ZERO64, 2'd0);
            st_next   = S_RD_HEAD;
          end
        S_RD_HEAD:
          if (mem_rsp.done)
          begin
            head_next = (mem_rsp.rdata[31:0] >= size32) ? 32'h00000000 : rdown(mem_rsp.rdata[31:0]);
            req_next  = mk(1'b0, pcb_addr + {56'h0, PCBR_OFF_THRESHOLD}, PCBR_ZERO64, 2'd0);
            st_next   = S_RD_THR;
          end
        S_RD_THR:
          if (mem_rsp.done)
          begin
            thr_next = rdown(mem_rsp.rdata[31:0]);
            req_next = mk(1'b0, pcb_addr + {56'h0, PCBR_OFF_DROPPED}, PCBR_ZERO64, 2'd1);
            st_next  = S_RD_DROP;
          end
        S_RD_DROP:
          if (mem_rsp.done)
          begin
            drop_next = mem_rsp.rdata;
            req_next  = '0;
            en_next   = 1'b1;
            pend_next = 1'b0;
            cnt_next  = reload_val;
            rnd_step  = 1'b1;
            st_next   = S_IDLE;
          end
        S_RD_TAIL:
          if (mem_rsp.done)
          begin
            tail_next = mem_rsp.rdata[31:0];
            req_next  = mk(1'b1, base_reg + {32'h0, head_reg}, event_data, 2'd1);
            st_next   = S_WR_REC;
          end
        S_WR_REC:
          if (mem_rsp.done)
          begin
            cnt_next = reload_val;
            rnd_step = 1'b1;
            if (head_adv == tail_reg)
            begin
              // ring full: the record just written gets overwritten next time
              drop_next = drop_reg + PCBR_ONE64;
              req_next  = mk(1'b1, pcb_addr + {56'h0, PCBR_OFF_DROPPED}, drop_reg + PCBR_ONE64, 2'd1);
              st_next   = S_INC_DROP;
            end
            else
            begin
              head_next = head_adv;
              irq_next  = flags_reg[PCBR_THR_IE_BIT] && (used >= thr_reg);
              req_next  = mk(1'b1, pcb_addr + {56'h0, PCBR_OFF_HEAD}, {32'h0, head_adv}, 2'd0);
              st_next   = S_WR_HEAD;
            end
          end
        S_WR_HEAD, S_INC_DROP:
          if (mem_rsp.done)
          begin
            req_next  = '0;
            done_next = 1'b1;
            st_next   = S_IDLE;
          end
        S_FAULT:
        begin
          exc_next  = 1'b1;
          en_next   = 1'b0;
          pend_next = 1'b0;
          st_next   = S_IDLE;
        end
        default:
          st_next = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_reg    <= S_IDLE;
      req_reg   <= '0;
      en_reg    <= 1'b0;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
      exc_reg   <= 1'b0;
      irq_reg   <= 1'b0;
      flags_reg <= 32'h00000000;
      head_reg  <= 32'h00000000;
      tail_reg  <= 32'h00000000;
      thr_reg   <= 32'h00000000;
      size_reg  <= PCBR_ZERO28;
      rnd_reg   <= 4'h0;
      base_reg  <= PCBR_ZERO64;
      drop_reg  <= PCBR_ZERO64;
      cnt_reg   <= '0;
      pend_reg  <= 1'b0;
    end
    else
    begin
      st_reg    <= st_next;
      req_reg   <= req_next;
      en_reg    <= en_next;
      busy_reg  <= busy_next;
      done_reg  <= done_next;
      exc_reg   <= exc_next;
      irq_reg   <= irq_next;
      flags_reg <= flags_next;
      head_reg  <= head_next;
      tail_reg  <= tail_next;
      thr_reg   <= thr_next;
      size_reg  <= size_next;
      rnd_reg   <= rnd_next;
      base_reg  <= base_next;
      drop_reg  <= drop_next;
      cnt_reg   <= cnt_next;
      pend_reg  <= pend_next;
    end
  end

  logic [7:0] evoff_reg;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      evoff_reg <= 8'h00;
    else
      evoff_reg <= PCBR_EVENT_AREA;
  end

  assign mem_req      = req_reg;
  assign enabled      = en_reg;
  assign busy         = busy_reg;
  assign event_done   = done_reg;
  assign exception    = exc_reg;
  assign thr_irq      = irq_reg;
  assign flags_en     = flags_reg;
  assign event_offset = evoff_reg;
  assign counter      = cnt_reg;

  // ==========================================================================
  // checks
  a_tail_never_written: assert property (@(posedge clk) disable iff (!rst_n)
    (req_reg.valid && req_reg.write) |-> (req_reg.addr != pcb_addr + {56'h0, PCBR_OFF_TAIL}))
    else $error("tail field written");
  a_fault_raises_exc: assert property (@(posedge clk) disable iff (!rst_n)
    (req_reg.valid && mem_rsp.done && mem_rsp.fault) |-> ##2 exc_reg)
    else $error("fault without exception");
  a_head_in_ring: assert property (@(posedge clk) disable iff (!rst_n)
    (en_reg && size_reg != PCBR_ZERO28) |-> (head_reg < size32) && (head_reg % REC_SIZE == 0))
    else $error("head out of ring");
  a_full_keeps_head: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg == S_WR_REC && mem_rsp.done && !mem_rsp.fault && head_adv == tail_reg)
    |=> (head_reg == $past(head_reg)) && (drop_reg == $past(drop_reg) + PCBR_ONE64))
    else $error("full ring mishandled");
  a_head_advances: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg == S_WR_REC && mem_rsp.done && !mem_rsp.fault && head_adv != tail_reg)
    |=> head_reg == $past(head_adv))
    else $error("head not advanced");
  a_flags_masked: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg == S_RD_FLAGS && mem_rsp.done && !mem_rsp.fault)
    |=> flags_reg == ($past(mem_rsp.rdata[31:0]) & $past(feature_cfg)))
    else $error("flags not masked");
  a_size_rounded: assert property (@(posedge clk) disable iff (!rst_n)
    en_reg |-> (size32 % REC_SIZE == 0))
    else $error("ring size not rounded");
  a_rec_at_head: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg == S_WR_REC && req_reg.valid) |-> req_reg.addr == base_reg + {32'h0, head_reg})
    else $error("record address wrong");
  a_load_reads_flags: assert property (@(posedge clk) disable iff (!rst_n)
    (st_reg == S_IDLE && load_instr) |=> st_reg == S_RD_FLAGS && req_reg.valid && !req_reg.write)
    else $error("load did not start");
endmodule // pcbr_ring

//--- pcbr_pkg.sv
// package for the profiling control block ring logic
package pcbr_pkg;

  // ==========================================================================
  // control block byte offsets
  localparam logic [7:0] PCBR_OFF_FLAGS     = 8'h00;
  localparam logic [7:0] PCBR_OFF_SIZE      = 8'h04;
  localparam logic [7:0] PCBR_OFF_BASE      = 8'h08;
  localparam logic [7:0] PCBR_OFF_HEAD      = 8'h10;
  localparam logic [7:0] PCBR_OFF_DROPPED   = 8'h18;
  localparam logic [7:0] PCBR_OFF_THRESHOLD = 8'h20;
  localparam logic [7:0] PCBR_OFF_TAIL      = 8'h40;
  localparam logic [7:0] PCBR_EVENT_AREA    = 8'h80;

  // ==========================================================================
  // field positions inside the 64-bit word at offset 0
  localparam int PCBR_SIZE_LSB  = 32;
  localparam int PCBR_SIZE_MSB  = 59;
  localparam int PCBR_RAND_LSB  = 60;
  localparam int PCBR_RAND_MSB  = 63;
  localparam int PCBR_THR_IE_BIT = 31;

  localparam logic [27:0] PCBR_ZERO28 = 28'h0000000;
  localparam logic [63:0] PCBR_ZERO64 = 64'h0000000000000000;
  localparam logic [63:0] PCBR_ONE64  = 64'h0000000000000001;

  // memory request carried to the memory port
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [63:0] addr;
    logic [63:0] wdata;
    logic [1:0]  size;   // 0:4 bytes 1:8 bytes
  } pcbr_mem_req_t;

  // answer from memory
  typedef struct packed {
    logic        done;
    logic        fault;  // read-only or unmapped
    logic [63:0] rdata;
  } pcbr_mem_rsp_t;

endpackage : pcbr_pkg

//--- pcbr_rand.sv
// pseudo-random source for counter low bits
module pcbr_rand
  import pcbr_pkg::*;
#(
  parameter int W = 26
)(
  input  wire logic         clk,    // core clock
  input  wire logic         rst_n,  // sync reset, active low
  input  wire logic         step,   // advance the sequence
  output logic [W-1:0]      value   // current random word
);
  logic [31:0] lfsr_reg;
  logic [31:0] lfsr_next;

  always_comb
  begin
    lfsr_next = lfsr_reg;
    if (step)
    begin
      lfsr_next = {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      lfsr_reg <= 32'hACE1ACE1;
    else
      lfsr_reg <= lfsr_next;
  end

  assign value = lfsr_reg[W-1:0];
endmodule // pcbr_rand

//--- pcbr_reload.sv
// counter reload with randomised low bits
module pcbr_reload
  import pcbr_pkg::*;
#(
  parameter int W = 26
)(
  input  wire logic [W-1:0] interval,  // programmed interval
  input  wire logic [3:0]   rand_bits, // count of random low bits
  input  wire logic [W-1:0] rnd,       // random word
  output logic [W-1:0]      reload     // value loaded into counter
);
  logic [W-1:0] mask;

  always_comb
  begin
    mask = '0;
    for (int i = 0; i < W; i++)
    begin
      if (i < int'(rand_bits))
        mask[i] = 1'b1;
    end
    reload = (interval & ~mask) | (rnd & mask);
  end
endmodule // pcbr_reload

//--- pcbr_mem_model.sv
// system memory model holding the control block and the event ring
module pcbr_mem_model
  import pcbr_pkg::*;
#(
  parameter logic [63:0] PCB = 64'h0000000000001000
)(
  input  wire logic          clk,     // core clock
  input  wire logic          rst_n,   // sync reset, active low
  input  wire pcbr_mem_req_t mem_req, // request from the block
  output pcbr_mem_rsp_t      mem_rsp  // answer to the block
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] mem [logic [60:0]];
  logic [63:0] flt_lo      = 64'hFFFFFFFFFFFFFFFF;
  logic [63:0] flt_hi      = 64'h0000000000000000;
  int          tail_wr_cnt = 0;
  int          wait_cnt    = 0;
  int          seed        = 88128;
  logic [63:0] word;
  // ==========================================================================
  // word access shared with the bench, which plays the draining software
  function automatic logic [63:0] rd(input logic [63:0] a);
    return mem.exists(a[63:3]) ? mem[a[63:3]] : 64'h0000000000000000;
  endfunction
  task automatic wr(input logic [63:0] a, input logic [63:0] d, input logic [1:0] sz);
    logic [63:0] w;
    w = rd(a);
    if (sz == 2'h1) w = d;
    else if (a[2]) w[63:32] = d[31:0];
    else w[31:0] = d[31:0];
    mem[a[63:3]] = w;
  endtask
  // ==========================================================================
  // answer after a random wait; rdata churns when no answer is given
  always @(posedge clk)
  begin
    mem_rsp.done  <= 1'b0;
    mem_rsp.fault <= 1'b0;
    mem_rsp.rdata <= {$random(seed), $random(seed)};
    word = rd(mem_req.addr);
    if (rst_n && mem_req.valid && !mem_rsp.done)
    begin
      if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
      else
      begin
        wait_cnt     <= $random(seed) & 3;
        mem_rsp.done <= 1'b1;
        if (mem_req.addr >= flt_lo && mem_req.addr <= flt_hi) mem_rsp.fault <= 1'b1;
        else if (mem_req.write)
        begin
          wr(mem_req.addr, mem_req.wdata, mem_req.size);
          if (mem_req.addr == PCB + PCBR_OFF_TAIL) tail_wr_cnt++;
        end
        else if (mem_req.size == 2'h1) mem_rsp.rdata <= word;
        // a half word is handed in both halves so either lane choice reads it
        else if (mem_req.addr[2]) mem_rsp.rdata <= {2{word[63:32]}};
        else mem_rsp.rdata <= {2{word[31:0]}};
      end
    end
  end
endmodule // pcbr_mem_model

//--- pcbr_ring_tb_top.sv
// self-checking testbench for the profiling control block ring logic
module pcbr_ring_tb_top
  import pcbr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] PCB  = 64'h0000000000001000;
  localparam logic [63:0] RING = 64'h0000000000002100; // segment base plus ring base
  logic          clk = 1'b0, rst_n = 1'b0, load_instr = 1'b0, disable_req = 1'b0, event_req = 1'b0;
  logic [63:0]   event_data  = 64'h0000000000000000;
  logic [31:0]   feature_cfg = 32'h800000A5;
  logic [25:0]   interval    = 26'h0000100;
  pcbr_mem_req_t mem_req;
  pcbr_mem_rsp_t mem_rsp;
  logic          enabled, busy, event_done, exception, thr_irq;
  logic [31:0]   flags_en;
  logic [7:0]    event_offset;
  logic [25:0]   counter;
  int            error_cnt = 0, total_checks = 0, irq_cnt = 0, seed = 88128;
  logic [63:0]   addr_q[$], data_q[$];
  logic [31:0]   heads[2] = '{32'h00000035, 32'h000000A0};
  logic [31:0]   used[2]  = '{32'h00000020, 32'h00000000};
  initial forever #2.5 clk = ~clk;
  pcbr_ring #(.CW(26), .REC_SIZE(32'h00000020)) u_pcbr_ring (.clk(clk), .rst_n(rst_n),
    .load_instr(load_instr), .disable_req(disable_req), .pcb_addr(PCB), .seg_base(64'h0000000000000100),
    .feature_cfg(feature_cfg), .event_req(event_req), .event_data(event_data), .interval(interval),
    .mem_rsp(mem_rsp), .mem_req(mem_req), .enabled(enabled), .busy(busy), .event_done(event_done),
    .exception(exception), .thr_irq(thr_irq), .flags_en(flags_en), .event_offset(event_offset),
    .counter(counter));
  pcbr_mem_model #(.PCB(PCB)) u_pcbr_mem_model (.clk(clk), .rst_n(rst_n), .mem_req(mem_req), .mem_rsp(mem_rsp));
  // ==========================================================================
  // shared tasks
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // 0 idle, 1 record handled, 2 exception
  task automatic wait_until(input int what);
    for (int n = 0; n < 300; n++)
    begin
      @(posedge clk);
      #1;
      if ((what == 0 && busy === 1'b0) || (what == 1 && event_done === 1'b1) || (what == 2 && exception === 1'b1))
        return;
    end
    chk("wait bound", 64'h1, 64'h0);
    finish_test();
  endtask
  task automatic pulse(input int which);
    @(posedge clk);
    if (which == 0) load_instr <= 1'b1; else if (which == 1) disable_req <= 1'b1; else event_req <= 1'b1;
    @(posedge clk);
    load_instr  <= 1'b0;
    disable_req <= 1'b0;
    event_req   <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic load_cb(input logic [31:0] head, input logic [3:0] rb);
    // size 0x8F is not a record multiple on purpose
    u_pcbr_mem_model.wr(PCB, {rb, 28'h000008F, 32'hFFFFFFFF}, 2'h1);
    u_pcbr_mem_model.wr(PCB + 8, 64'h0000000000002000, 2'h1);
    u_pcbr_mem_model.wr(PCB + 16, {32'h00000000, head}, 2'h1);
    u_pcbr_mem_model.wr(PCB + 24, 64'h0000000000000000, 2'h1);
    u_pcbr_mem_model.wr(PCB + 32, 64'h0000000000000040, 2'h1);
    u_pcbr_mem_model.wr(PCB + 64, 64'h0000000000000000, 2'h1);
    pulse(0);
    wait_until(0);
    chk("counter high", counter >> rb, interval >> rb);
  endtask
  task automatic do_event(input logic [63:0] exp_addr, input bit note);
    logic [63:0] d;
    d = {$random(seed), $random(seed)};
    if (note)
    begin
      addr_q.push_back(exp_addr);
      data_q.push_back(d);
    end
    @(posedge clk);
    event_data <= d;
    pulse(2);
    if (note) wait_until(1);
    wait_until(0);
  endtask
  // ==========================================================================
  // watcher: each record write takes the oldest note
  always @(posedge clk)
  begin
    if (thr_irq === 1'b1) irq_cnt++;
    if (mem_req.valid === 1'b1 && mem_req.write === 1'b1 && mem_rsp.done === 1'b1 && mem_rsp.fault === 1'b0 &&
        mem_req.addr[63:12] == 52'h2)
    begin
      if (addr_q.size() == 0) chk("unexpected record", 64'h1, 64'h0);
      else
      begin
        chk("record addr", mem_req.addr, addr_q.pop_front());
        chk("record data", mem_req.wdata, data_q.pop_front());
      end
    end
  end
  // ==========================================================================
  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    load_cb(32'h00000000, 4'h0);
    chk("enabled", enabled, 64'h1);
    chk("flags_en", flags_en, 64'h800000A5);
    chk("flags word", u_pcbr_mem_model.rd(PCB), {4'h0, 28'h000008F, 32'h800000A5});
    chk("base field", u_pcbr_mem_model.rd(PCB + 8), 64'h2000);
    chk("event_offset", event_offset, 64'h80);
    $display("test load done");
    for (int i = 0; i < 4; i++)
    begin
      do_event(RING + 32 * i, 1'b1);
      chk("head", u_pcbr_mem_model.rd(PCB + 16) & 64'hFFFFFFFF, (i < 3) ? 32 * (i + 1) : 64'h60);
    end
    chk("dropped", u_pcbr_mem_model.rd(PCB + 24), 64'h1);
    chk("irq count", irq_cnt, 64'h2);
    u_pcbr_mem_model.wr(PCB + 64, 64'h0000000000000040, 2'h0);
    do_event(RING + 64'h60, 1'b1);
    chk("head wrap", u_pcbr_mem_model.rd(PCB + 16) & 64'hFFFFFFFF, 64'h0);
    chk("irq count", irq_cnt, 64'h3);
    $display("test ring done");
    pulse(1);
    chk("disabled", enabled, 64'h0);
    do_event(RING, 1'b0);
    repeat (30) @(posedge clk);
    chk("no record", addr_q.size(), 64'h0);
    chk("head idle", u_pcbr_mem_model.rd(PCB + 16) & 64'hFFFFFFFF, 64'h0);
    // an odd head is rounded down, one past the ring is replaced by zero
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      interval <= 26'($random(seed));
      load_cb(heads[i], 4'(4 + 4 * i));
      do_event(RING + used[i], 1'b1);
      chk("counter reload", counter >> (4 + 4 * i), interval >> (4 + 4 * i));
      pulse(1);
    end
    $display("test head done");
    load_cb(32'h00000000, 4'h0);
    u_pcbr_mem_model.flt_lo = 64'h0000000000002000;
    u_pcbr_mem_model.flt_hi = 64'h0000000000002FFF;
    @(posedge clk);
    event_data <= 64'h0000000000000000;
    pulse(2);
    wait_until(2);
    wait_until(0);
    chk("enabled after fault", enabled, 64'h0);
    chk("tail writes", u_pcbr_mem_model.tail_wr_cnt, 64'h0);
    $display("test fault done");
    finish_test();
  end
endmodule // pcbr_ring_tb_top
